// File: rx_filter_pkg.sv
// Package with register map, field layout and shared types of the receive filter block
package rx_filter_pkg;
  localparam logic [7:0] COLL_CFG_ADDR = 8'h05;
  localparam logic [7:0] SST_ADDR = 8'h06;
  localparam logic [7:0] RXCFG1_ADDR = 8'h0b;
  localparam logic [7:0] MASK_CFG_ADDR = 8'h20;
  localparam logic [7:0] STATUS_ADDR = 8'h21;
  localparam logic [7:0] COLL_CFG_RESET = 8'h00;
  localparam logic [7:0] SST_RESET = 8'h00;
  localparam logic [7:0] RXCFG1_RESET = 8'h00;
  localparam logic [7:0] MASK_CFG_RESET = 8'h00;
  localparam logic [7:0] COLL_CFG_MASK = 8'hcf;
  localparam logic [7:0] SST_MASK = 8'h1f;
  localparam int SUPPRESS_BIT = 7;
  localparam int START_TOL_BIT = 6;
  localparam int CHOICE_BIT = 7;
  localparam int START_BITS = 4;
  // One etu at 106 kb/s is 128 carrier periods; sst steps are a quarter etu
  localparam int ETU_NS = 9440;
  localparam int STEP_NS = ETU_NS / 4;
  localparam int CLK_NS = 100;
  localparam int STEP_CYCLES = (STEP_NS / CLK_NS) < 1 ? 1 : (STEP_NS / CLK_NS);
  localparam int MASK_UNIT_CYCLES = 8;

  typedef enum logic [1:0] {MODE_OTHER, MODE_A106, MODE_B106} rx_mode_t;

  typedef struct packed {
    logic [2:0] low_pass;
    logic [3:0] zero_set;
    logic am_enable;
    logic pm_enable;
    logic framing_pm;
  } analog_cfg_t;

  typedef struct packed {
    logic frame_end;
    logic frame_error;
    logic [3:0] frame_bytes;
    logic bit_error;
    logic [3:0] bit_index;
    logic subcarrier_seen;
  } rx_event_t;
endpackage : rx_filter_pkg

// File: nfc_rx_disturbance_filter.sv
// Receive disturbance filter: collision suppression, subcarrier start check, channel choice
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
// Operation
// - ISO-A 106k start interrupt needs error-free first four bits unless tolerant set.
// - Errored frame is EMD only when shorter than short_frame_threshold bytes.
// - subcarrier_start_limit is 5 bits of 0.25 etu; upper three bits reserved.
// - ISO-B 106k subcarrier earlier than limit after mask timer raises soft error.
// - With suppression on, early subcarrier discards frame as EMD and raises restart.
// - With one channel enabled, channel_choice 0 enables AM, 1 enables PM.
// - With both channels and manual selection, channel_choice picks framing channel.
// - Low-pass and zero settings are stored, reset to zero, forwarded to analog.
// - Mask timer starts at end of transmission; receiver activity ignored until expiry.
module nfc_rx_disturbance_filter (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // Receiver status
  input wire rx_filter_pkg::rx_mode_t rx_mode,
  input wire logic single_channel,
  input wire logic manual_select,
  input wire logic tx_end,
  input wire rx_filter_pkg::rx_event_t rx_event,
  // Events and analog settings
  output logic receive_start_irq,
  output logic soft_error_irq,
  output logic restart_irq,
  output logic emd_discard,
  output logic frame_accept,
  output logic rx_active,
  output rx_filter_pkg::analog_cfg_t analog_cfg
);
  import rx_filter_pkg::*;

  // Configuration registers and the registered read port
  logic [7:0] coll_reg, coll_next;
  logic [7:0] sst_reg, sst_next;
  logic [7:0] cfg1_reg, cfg1_next;
  logic [7:0] mask_cfg_reg, mask_cfg_next;
  logic [7:0] rdata_reg, rdata_next;
  // Mask receive timer, plus the quarter-etu clock of the start-time measurement
  logic mask_reg, mask_next;
  logic [15:0] mask_cnt_reg, mask_cnt_next;
  logic [7:0] step_cnt_reg, step_cnt_next;
  logic [5:0] start_time_reg, start_time_next;
  logic early_reg, early_next;
  logic start_ok_reg, start_ok_next;
  logic start_sent_reg, start_sent_next;
  logic [7:0] evt_reg, evt_next;
  logic suppress_on;
  logic b106;

  always_comb begin
    coll_next = coll_reg;
    sst_next = sst_reg;
    cfg1_next = cfg1_reg;
    mask_cfg_next = mask_cfg_reg;
    rdata_next = 8'h00;
    if (wr_en) begin
      unique case (addr)
        COLL_CFG_ADDR: coll_next = wdata & COLL_CFG_MASK;
        SST_ADDR: sst_next = wdata & SST_MASK;
        RXCFG1_ADDR: cfg1_next = wdata;
        // Unmapped writes fall through, so a stray address cannot disturb settings
        MASK_CFG_ADDR: mask_cfg_next = wdata;
        default: ;
      endcase
    end
    if (rd_en) begin
      unique case (addr)
        COLL_CFG_ADDR: rdata_next = coll_reg;
        SST_ADDR: rdata_next = sst_reg;
        RXCFG1_ADDR: rdata_next = cfg1_reg;
        MASK_CFG_ADDR: rdata_next = mask_cfg_reg;
        STATUS_ADDR: rdata_next = {4'h0, early_reg, mask_reg, emd_discard, rx_active};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      coll_reg <= COLL_CFG_RESET;
      sst_reg <= SST_RESET;
      cfg1_reg <= RXCFG1_RESET;
      mask_cfg_reg <= MASK_CFG_RESET;
      rdata_reg <= 8'h00;
    end else begin
      coll_reg <= coll_next;
      sst_reg <= sst_next;
      cfg1_reg <= cfg1_next;
      mask_cfg_reg <= mask_cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

  // Suppression gates every EMD decision; the tolerant bit only touches ISO-A
  assign suppress_on = coll_reg[SUPPRESS_BIT];
  assign b106 = (rx_mode == MODE_B106);

  // tx_end wins over all activity, so each exchange starts from a clean slate
  always_comb begin
    mask_next = mask_reg;
    mask_cnt_next = mask_cnt_reg;
    step_cnt_next = step_cnt_reg;
    start_time_next = start_time_reg;
    early_next = early_reg;
    start_ok_next = start_ok_reg;
    start_sent_next = start_sent_reg;
    evt_next = 8'h00;
    if (tx_end) begin
      mask_next = 1'b1;
      mask_cnt_next = 16'h0000;
      step_cnt_next = 8'h00;
      start_time_next = 6'h00;
      early_next = 1'b0;
      start_ok_next = 1'b1;
      start_sent_next = 1'b0;
    end else if (mask_reg) begin
      // Activity while masked is dropped entirely
      if (mask_cnt_reg >= 16'(mask_cfg_reg * MASK_UNIT_CYCLES)) begin
        mask_next = 1'b0;
      end else begin
        // Counting stops once the mask drops, so a long setting never wraps
        mask_cnt_next = mask_cnt_reg + 16'h0001;
      end
    end else begin
      if (!start_sent_reg && !rx_event.subcarrier_seen) begin
        if (step_cnt_reg == 8'(STEP_CYCLES - 1)) begin
          step_cnt_next = 8'h00;
          if (start_time_reg != 6'h3f) start_time_next = start_time_reg + 6'h01;
        end else begin
          step_cnt_next = step_cnt_reg + 8'h01;
        end
      end
      if (b106 && rx_event.subcarrier_seen && !start_sent_reg) begin
        start_sent_next = 1'b1;
        if (start_time_reg < {1'b0, sst_reg[4:0]}) begin
          early_next = 1'b1;
          evt_next[1] = 1'b1;
          if (suppress_on) begin
            evt_next[2] = 1'b1;
            evt_next[3] = 1'b1;
          end
        end
      end
      if (rx_mode == MODE_A106 && !start_sent_reg) begin
        if (rx_event.bit_error && rx_event.bit_index < 4'(START_BITS)) begin
          start_ok_next = 1'b0;
        end
        if (rx_event.bit_index == 4'(START_BITS)) begin
          start_sent_next = 1'b1;
          // Tolerant mode forgives errors within the first four bits
          evt_next[0] = start_ok_reg || coll_reg[START_TOL_BIT];
        end
      end
      if (rx_event.frame_end) begin
        // An errored short frame is EMD only while suppression is on
        if (suppress_on && rx_event.frame_error &&
            rx_event.frame_bytes < coll_reg[3:0]) begin
          evt_next[3] = 1'b1;
          evt_next[2] = 1'b1;
        end else if (!(b106 && early_reg && suppress_on)) begin
          evt_next[4] = 1'b1;
        end
        mask_next = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= 1'b0;
      mask_cnt_reg <= 16'h0000;
      step_cnt_reg <= 8'h00;
      start_time_reg <= 6'h00;
      early_reg <= 1'b0;
      start_ok_reg <= 1'b1;
      start_sent_reg <= 1'b0;
      evt_reg <= 8'h00;
    end else begin
      mask_reg <= mask_next;
      mask_cnt_reg <= mask_cnt_next;
      step_cnt_reg <= step_cnt_next;
      start_time_reg <= start_time_next;
      early_reg <= early_next;
      start_ok_reg <= start_ok_next;
      start_sent_reg <= start_sent_next;
      evt_reg <= evt_next;
    end
  end

  assign receive_start_irq = evt_reg[0];
  assign soft_error_irq = evt_reg[1];
  assign restart_irq = evt_reg[2];
  assign emd_discard = evt_reg[3];
  assign frame_accept = evt_reg[4];
  assign rx_active = !mask_reg;

  always_comb begin
    analog_cfg.low_pass = cfg1_reg[6:4];
    analog_cfg.zero_set = cfg1_reg[3:0];
    // Both enabled from the operation control side means the choice only picks framing
    analog_cfg.am_enable = single_channel ? !cfg1_reg[CHOICE_BIT] : 1'b1;
    analog_cfg.pm_enable = single_channel ? cfg1_reg[CHOICE_BIT] : 1'b1;
    // With both channels and no manual selection the framing stays on AM
    analog_cfg.framing_pm = (single_channel || manual_select) ? cfg1_reg[CHOICE_BIT] : 1'b0;
  end
endmodule : nfc_rx_disturbance_filter

// File: nfc_rx_card_model.sv
// Card side model producing receive events over the field
`timescale 1ns/1ps
module nfc_rx_card_model (
  // Clock
  input wire logic sys_clk,
  // Receive events
  output rx_filter_pkg::rx_event_t rx_event
);
  import rx_filter_pkg::*;
  // Quiet field between frames: no event flag stays up
  initial rx_event = '0;
  task automatic frame(input logic err, input logic [3:0] nb);
    for (int i = 0; i <= 4; i++) begin
      rx_event <= '{1'b0, 1'b0, 4'h0, err && i == 2, 4'(i), 1'b0};
      @(posedge sys_clk);
    end
    rx_event <= '{1'b1, err, nb, 1'b0, 4'h0, 1'b0};
    @(posedge sys_clk);
    rx_event <= '0;
  endtask : frame
  // Slow or prompt card: dly sets the subcarrier onset
  task automatic carrier(input int dly);
    repeat (dly) @(posedge sys_clk);
    rx_event <= '{1'b0, 1'b0, 4'h0, 1'b0, 4'h0, 1'b1};
    @(posedge sys_clk);
    rx_event <= '0;
  endtask : carrier
endmodule : nfc_rx_card_model

// File: nfc_rx_disturbance_filter_checker.sv
// Port checker for the receive disturbance filter
`timescale 1ns/1ps
module nfc_rx_disturbance_filter_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  // Receiver side
  input wire rx_filter_pkg::rx_mode_t rx_mode,
  input wire logic single_channel,
  input wire rx_filter_pkg::rx_event_t rx_event,
  input wire logic receive_start_irq,
  input wire logic soft_error_irq,
  input wire logic restart_irq,
  input wire logic emd_discard,
  input wire logic frame_accept,
  input wire logic rx_active,
  input wire rx_filter_pkg::analog_cfg_t analog_cfg
);
  import rx_filter_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence cfg_wr;
    wr_en && addr == RXCFG1_ADDR;
  endsequence
  AST_CFG: assert property (cfg_wr |=> analog_cfg.low_pass == $past(wdata[6:4]) &&
    analog_cfg.zero_set == $past(wdata[3:0])) else $error("analog setting lost");
  AST_SST_RSV: assert property (rd_en && addr == SST_ADDR |=> rdata[7:5] == 3'h0)
    else $error("limit reserved bits set");
  AST_COLL_RSV: assert property (rd_en && addr == COLL_CFG_ADDR |=> rdata[5:4] == 2'h0)
    else $error("config reserved bits set");
  AST_ONE: assert property (single_channel |-> analog_cfg.am_enable != analog_cfg.pm_enable)
    else $error("channel enables wrong");
  AST_START: assert property (receive_start_irq |-> $past(rx_mode) == MODE_A106 &&
    $past(rx_event.bit_index) == 4'h4) else $error("start irq without cause");
  AST_SOFT: assert property (soft_error_irq |-> $past(rx_mode) == MODE_B106 &&
    $past(rx_event.subcarrier_seen)) else $error("soft error without cause");
  AST_RESTART: assert property (restart_irq |-> emd_discard && !frame_accept)
    else $error("restart without discard");
  AST_EMD: assert property (emd_discard |-> soft_error_irq ||
    $past(rx_event.frame_end && rx_event.frame_error)) else $error("discard without error");
  AST_MASK: assert property (receive_start_irq || soft_error_irq |-> $past(rx_active))
    else $error("event while masked");
endmodule : nfc_rx_disturbance_filter_checker
bind nfc_rx_disturbance_filter nfc_rx_disturbance_filter_checker chk_i (.sys_clk(sys_clk),
  .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .rx_mode(rx_mode), .single_channel(single_channel), .rx_event(rx_event),
  .receive_start_irq(receive_start_irq), .soft_error_irq(soft_error_irq),
  .restart_irq(restart_irq), .emd_discard(emd_discard), .frame_accept(frame_accept),
  .rx_active(rx_active), .analog_cfg(analog_cfg));

// File: nfc_rx_disturbance_filter_test.sv
// Self-checking bench for the receive disturbance filter
`timescale 1ns/1ps
module nfc_rx_disturbance_filter_test;
  import rx_filter_pkg::*;
  logic sys_clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, single_channel = 0, manual_select = 0;
  logic tx_end = 0, rs, se, rt, emd, acc, act;
  logic [7:0] addr = 0, wdata = 0, rdata, v;
  rx_mode_t rx_mode = MODE_OTHER;
  rx_event_t rx_event;
  analog_cfg_t acfg;
  logic [4:0] pulses;
  int error_cnt = 0, compares = 0, seed = 32'h217e_865e, n[5];
  always #50 sys_clk = ~sys_clk;
  nfc_rx_disturbance_filter dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rx_mode(rx_mode),
    .single_channel(single_channel), .manual_select(manual_select), .tx_end(tx_end),
    .rx_event(rx_event), .receive_start_irq(rs), .soft_error_irq(se), .restart_irq(rt),
    .emd_discard(emd), .frame_accept(acc), .rx_active(act), .analog_cfg(acfg));
  nfc_rx_card_model card (.sys_clk(sys_clk), .rx_event(rx_event));
  // Pulses stand a whole cycle, so the falling edge counts them without racing the driver
  assign pulses = {acc, emd, rt, se, rs};
  always @(negedge sys_clk)
    foreach (n[i]) if (pulses[i] === 1'b1) n[i]++;
  function automatic logic [7:0] cnt();
    return {3'h0, n[0] == 1, n[1] == 1, n[2] == 1, n[3] == 1, n[4] == 1};
  endfunction : cnt
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(posedge sys_clk);
    chk(rdata, exp);
  endtask : rd
  // Every exchange opens with an end of transmission, which re-arms start detection
  task automatic arm;
    n = '{default: 0};
    tx_end <= 1'b1;
    @(posedge sys_clk);
    tx_end <= 1'b0;
  endtask : arm
  task automatic txe(input int dly);
    arm();
    card.carrier(dly);
    repeat (2) @(posedge sys_clk);
  endtask : txe
  task automatic stop_test;
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    #1_000_000;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(COLL_CFG_ADDR, 8'h00);
    rd(SST_ADDR, 8'h00);
    rd(RXCFG1_ADDR, 8'h00);
    rd(8'h3c, 8'h00);
    repeat (8) begin
      v = 8'($random(seed));
      wr(COLL_CFG_ADDR, v);
      rd(COLL_CFG_ADDR, v & 8'hcf);
      wr(SST_ADDR, ~v);
      rd(SST_ADDR, ~v & 8'h1f);
      wr(RXCFG1_ADDR, v);
      chk({1'b0, acfg.low_pass, acfg.zero_set}, {1'b0, v[6:0]});
      single_channel <= 1'b1;
      @(posedge sys_clk);
      chk({6'h0, acfg.am_enable, acfg.pm_enable}, {6'h0, !v[7], v[7]});
      single_channel <= 1'b0;
      manual_select <= 1'b1;
      @(posedge sys_clk);
      chk({7'h0, acfg.framing_pm}, {7'h0, v[7]});
      manual_select <= 1'b0;
      @(posedge sys_clk);
      chk({7'h0, acfg.framing_pm}, 8'h00);
    end
    rx_mode <= MODE_A106;
    for (int t = 0; t < 3; t++) begin
      wr(COLL_CFG_ADDR, {1'b0, t == 1, 6'h04});
      arm();
      @(posedge sys_clk);
      card.frame(t < 2, 4'h8);
      repeat (2) @(posedge sys_clk);
      v = cnt();
      chk({7'h0, v[4]}, {7'h0, t > 0});
    end
    wr(COLL_CFG_ADDR, 8'hc4);
    for (int b = 3; b < 5; b++) begin
      arm();
      @(posedge sys_clk);
      card.frame(1'b1, 4'(b));
      repeat (2) @(posedge sys_clk);
      chk(cnt(), b == 3 ? 8'h16 : 8'h11);
    end
    rx_mode <= MODE_B106;
    wr(SST_ADDR, 8'h02);
    for (int e = 0; e < 3; e++) begin
      wr(COLL_CFG_ADDR, {e > 0, 7'h44});
      txe(e == 2 ? 60 : 10);
      chk(cnt(), e == 2 ? 8'h00 : {4'h0, 1'b1, e[0], e[0], 1'b0});
    end
    wr(MASK_CFG_ADDR, 8'h04);
    txe(5);
    chk(cnt(), 8'h00);
    chk({7'h0, act}, 8'h00);
    rd(STATUS_ADDR, 8'h04);
    repeat (30) @(posedge sys_clk);
    chk({7'h0, act}, 8'h01);
    stop_test();
  end
endmodule : nfc_rx_disturbance_filter_test
